/* File: bsr_regs.vh */
// constants for the four-stage bidirectional shift register
// assumes inclusion by bsr_core.v only; definitions, no logic
`ifndef BSR_REGS_VH
`define BSR_REGS_VH

// stage word width and reset value
`define BSR_WIDTH 4
`define BSR_STAGE_RST 4'h0

// snapshot fifo shape
`define BSR_FIFO_DEPTH 8
`define BSR_FIFO_AW 3

// input synchroniser reset levels
`define BSR_SYNC_RST 1'b0
`define BSR_PAR_SYNC_RST 4'h0

// mode encodings
`define BSR_MODE_RIGHT 1'b0
`define BSR_MODE_LOAD 1'b1

`endif

/* File: bsr_core.v */
// four-stage shift register with right shift, parallel load and a snapshot fifo
// assumes all pin inputs are asynchronous to sys_clk_i and change slowly
// against the 50 ns system clock; no software registers are reached
//
// Contract
// - both clock pins act only on their falling transition
// - mode high, load clock falling: parallel inputs captured into stages in order
// - mode low, right clock falling: serial into stage one, others shift on
// - inactive mode's clock and data inputs are ignored
// - stages hold on steady clocks and on any mode change
`timescale 1ns/10ps
`include "bsr_regs.vh"

// ****************************************************************
// snapshot fifo
// ****************************************************************
module bsr_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    // clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // storage has no reset; it is only read while count is nonzero
    always @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // bsr_fifo

// ****************************************************************
// shift register core
// ****************************************************************
module bsr_core
(
    // clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // pins from outside logic
    input wire mode_i,
    input wire right_clk_i,
    input wire load_clk_i,
    input wire serial_i,
    input wire [3:0] par_i,
    // stage outputs
    output wire stage1_out_o,
    output wire stage2_out_o,
    output wire stage3_out_o,
    output wire stage4_out_o,
    // snapshot stream, one word per stage update while the fifo has room
    output wire snap_valid_o,
    input wire snap_ready_i,
    output wire [3:0] snap_data_o,
    output wire snap_room_o
);
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    reg mode_s1_reg;
    reg mode_s2_reg;
    reg rclk_s1_reg;
    reg rclk_s2_reg;
    reg rclk_s3_reg;
    reg lclk_s1_reg;
    reg lclk_s2_reg;
    reg lclk_s3_reg;
    reg ser_s1_reg;
    reg ser_s2_reg;
    reg [3:0] par_s1_reg;
    reg [3:0] par_s2_reg;
    reg [3:0] stage_reg;
    reg [3:0] stage_next;
    reg update_next;
    wire rclk_fall;
    wire lclk_fall;
    wire fifo_room;

    // edge detect reads only the second and third flops, never the first
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mode_s1_reg <= `BSR_SYNC_RST;
            mode_s2_reg <= `BSR_SYNC_RST;
            rclk_s1_reg <= `BSR_SYNC_RST;
            rclk_s2_reg <= `BSR_SYNC_RST;
            rclk_s3_reg <= `BSR_SYNC_RST;
            lclk_s1_reg <= `BSR_SYNC_RST;
            lclk_s2_reg <= `BSR_SYNC_RST;
            lclk_s3_reg <= `BSR_SYNC_RST;
            ser_s1_reg <= `BSR_SYNC_RST;
            ser_s2_reg <= `BSR_SYNC_RST;
            par_s1_reg <= `BSR_PAR_SYNC_RST;
            par_s2_reg <= `BSR_PAR_SYNC_RST;
        end
        else
        begin
            mode_s1_reg <= mode_i;
            mode_s2_reg <= mode_s1_reg;
            rclk_s1_reg <= right_clk_i;
            rclk_s2_reg <= rclk_s1_reg;
            rclk_s3_reg <= rclk_s2_reg;
            lclk_s1_reg <= load_clk_i;
            lclk_s2_reg <= lclk_s1_reg;
            lclk_s3_reg <= lclk_s2_reg;
            ser_s1_reg <= serial_i;
            ser_s2_reg <= ser_s1_reg;
            par_s1_reg <= par_i;
            par_s2_reg <= par_s1_reg;
        end
    end

    // ****************************************************************
    // stage update
    // ****************************************************************
    // rising edges and steady levels produce no event at all
    assign rclk_fall = rclk_s3_reg & ~rclk_s2_reg;
    assign lclk_fall = lclk_s3_reg & ~lclk_s2_reg;

    // mode is only a selector; its own edges never start an update
    always @*
    begin
        stage_next = stage_reg;
        update_next = 1'b0;
        if (mode_s2_reg == `BSR_MODE_LOAD)
        begin
            // right clock and serial input are not looked at here
            if (lclk_fall)
            begin
                // with outside feedback wiring this is the left shift
                stage_next = par_s2_reg;
                update_next = 1'b1;
            end
        end
        else
        begin
            // load clock and parallel inputs are not looked at here
            if (rclk_fall)
            begin
                stage_next = {stage_reg[2:0], ser_s2_reg};
                update_next = 1'b1;
            end
        end
    end

    // bit 0 is stage one; the right shift moves bit n into bit n+1
    always @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            stage_reg <= `BSR_STAGE_RST;
        end
        else
        begin
            stage_reg <= stage_next;
        end
    end

    assign stage1_out_o = stage_reg[0];
    assign stage2_out_o = stage_reg[1];
    assign stage3_out_o = stage_reg[2];
    assign stage4_out_o = stage_reg[3];

    // ****************************************************************
    // snapshot buffer
    // ****************************************************************
    // the pins cannot be stalled, so a full fifo drops the snapshot while
    // the stages still update; snap_room_o lets the consumer see this
    bsr_fifo #(
        .WIDTH(`BSR_WIDTH),
        .DEPTH(`BSR_FIFO_DEPTH),
        .AW(`BSR_FIFO_AW)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(update_next),
        .in_ready_o(fifo_room),
        .in_data_i(stage_next),
        .out_valid_o(snap_valid_o),
        .out_ready_i(snap_ready_i),
        .out_data_o(snap_data_o)
    );

    assign snap_room_o = fifo_room;
endmodule // bsr_core

/* File: bsr_checker.sv */
// checker for the shift register core, bound to its ports
// assumes pin edges spaced at least 3 system clocks apart
`timescale 1ns/10ps
module bsr_checker
(
    // clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // pins
    input wire mode_i,
    input wire right_clk_i,
    input wire load_clk_i,
    input wire serial_i,
    input wire [3:0] par_i,
    // outputs
    input wire stage1_out_o,
    input wire stage2_out_o,
    input wire stage3_out_o,
    input wire stage4_out_o,
    input wire snap_valid_o,
    input wire snap_room_o
);
    wire [3:0] q = {stage4_out_o, stage3_out_o, stage2_out_o, stage1_out_o};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // a pin fall reaches the stages three samples later, through the sync chain
    a_right_shift:
    assert property ($fell(right_clk_i) && !mode_i |-> ##3
        q == {$past(q[2:0], 3), $past(serial_i, 3)}) else $error("right shift wrong");
    a_load_capture:
    assert property ($fell(load_clk_i) && mode_i |-> ##3 q == $past(par_i, 3))
        else $error("parallel load wrong");
    a_idle_clock_ignored:
    assert property (($fell(load_clk_i) && !mode_i) || ($fell(right_clk_i) && mode_i)
        |-> ##3 $stable(q)) else $error("inactive clock changed stages");
    a_no_fall_hold:
    assert property ((!$fell(right_clk_i) && !$fell(load_clk_i))[*4] |=> $stable(q))
        else $error("stages moved without a falling clock");
    a_update_snapped:
    assert property (!$stable(q) |-> snap_valid_o) else $error("update not snapped");
    a_full_valid:
    assert property (!snap_room_o |-> snap_valid_o) else $error("full but empty");
endmodule // bsr_checker

bind bsr_core bsr_checker chk (.sys_clk_i, .rstn_i, .mode_i, .right_clk_i, .load_clk_i,
    .serial_i, .par_i, .stage1_out_o, .stage2_out_o, .stage3_out_o, .stage4_out_o,
    .snap_valid_o, .snap_room_o);

/* File: bsr_pins.sv */
// model of the outside logic driving mode, clocks and data pins
// assumes tasks are called from the falling edge of sys_clk_i
`timescale 1ns/10ps
module bsr_pins
(
    // clock and stage feedback
    input wire sys_clk_i,
    input wire [3:0] q_i,
    // pins
    output logic mode_o,
    output logic right_clk_o,
    output logic load_clk_o,
    output logic serial_o,
    output logic [3:0] par_o
);
    initial {mode_o, right_clk_o, load_clk_o, serial_o, par_o} = 8'h00;
    // four cycles per level, one more than the sync chain needs
    task automatic wait4;
        repeat (4) @(negedge sys_clk_i);
    endtask
    // called only between pulses, so both clocks are low
    task automatic set_mode(input logic m);
        wait4();
        mode_o = m;
        wait4();
    endtask
    task automatic pulse(input logic rclk, input logic [4:0] d);
        {serial_o, par_o} = d;
        wait4();
        if (rclk)
            right_clk_o = 1'b1;
        else
            load_clk_o = 1'b1;
        wait4();
        {right_clk_o, load_clk_o} = 2'h0;
        wait4();
    endtask
    // outputs fed back one input down, new bit on the top input
    task automatic left(input logic b);
        pulse(1'b0, {1'b0, b, q_i[3:1]});
    endtask
endmodule // bsr_pins

/* File: testbench.sv */
// self-checking bench for the shift register core and its snapshot fifo
// assumes bsr_pins drives every pin and the checker is bound to the core
`timescale 1ns/10ps
module testbench;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic snap_ready_i = 1'b0;
    wire mode, rclk, lclk, ser, sv, room;
    wire [3:0] par, q, sd;
    int failures = 0;
    int n_compared = 0;
    logic [3:0] exp_q = 4'h0;
    logic [3:0] snaps[$];
    always #25 sys_clk_i = ~sys_clk_i;
    bsr_pins pins (.sys_clk_i(sys_clk_i), .q_i(q), .mode_o(mode), .right_clk_o(rclk),
        .load_clk_o(lclk), .serial_o(ser), .par_o(par));
    bsr_core dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mode_i(mode), .right_clk_i(rclk),
        .load_clk_i(lclk), .serial_i(ser), .par_i(par), .stage1_out_o(q[0]),
        .stage2_out_o(q[1]), .stage3_out_o(q[2]), .stage4_out_o(q[3]), .snap_valid_o(sv),
        .snap_ready_i(snap_ready_i), .snap_data_o(sd), .snap_room_o(room));
    task automatic check(input logic [3:0] got, input logic [3:0] want);
        n_compared++;
        if (got !== want)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // shift with serial = ~stage1 so every update changes the word
    task automatic shift_right;
        logic b;
        b = ~exp_q[0];
        pins.pulse(1'b1, {b, 4'h0});
        exp_q = {exp_q[2:0], b};
    endtask
    task automatic t_right_and_ignored_load;
        pins.set_mode(1'b0);
        repeat (4)
        begin
            shift_right();
            check(q, exp_q);
        end
        pins.pulse(1'b0, {1'b0, 4'hf});
        check(q, exp_q);
    endtask
    task automatic t_load_and_left;
        pins.set_mode(1'b1);
        pins.pulse(1'b0, {1'b0, 4'h6});
        exp_q = 4'h6;
        check(q, exp_q);
        pins.pulse(1'b1, {1'b1, 4'h5});
        check(q, exp_q);
        pins.left(1'b1);
        exp_q = {1'b1, exp_q[3:1]};
        check(q, exp_q);
        pins.set_mode(1'b0);
        check(q, exp_q);
    endtask
    // fifo filled past its depth with the consumer stalled, then drained
    task automatic t_fifo_fill_drain;
        int i;
        snap_ready_i = 1'b1;
        for (i = 0; i < 20 && sv; i++)
            @(negedge sys_clk_i);
        snap_ready_i = 1'b0;
        check({3'h0, sv}, 4'h0);
        check({3'h0, room}, 4'h1);
        repeat (9)
        begin
            shift_right();
            if (snaps.size() < 8)
                snaps.push_back(exp_q);
        end
        check(q, exp_q);
        check({3'h0, room}, 4'h0);
        repeat (8)
        begin
            check({3'h0, sv}, 4'h1);
            check(sd, snaps.pop_front());
            snap_ready_i = 1'b1;
            @(negedge sys_clk_i);
            snap_ready_i = 1'b0;
            @(negedge sys_clk_i);
        end
        check({3'h0, sv}, 4'h0);
    endtask
    initial
    begin
        repeat (2) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        check(q, 4'h0);
        t_right_and_ignored_load();
        t_load_and_left();
        t_fifo_fill_drain();
        end_of_test();
    end
endmodule // testbench
